// ===== rtl/tbpwm_params.svh
`ifndef TBPWM_PARAMS_SVH
`define TBPWM_PARAMS_SVH

// register offsets on the plain register port
`define TBPWM_A_DUTY_UP   3'h0
`define TBPWM_A_DUTY_LO   3'h1
`define TBPWM_A_CTRL      3'h2
`define TBPWM_A_TCTRL     3'h3
`define TBPWM_A_LIMIT     3'h4
`define TBPWM_A_COUNT     3'h5
`define TBPWM_A_RES       3'h6

// field positions
`define TBPWM_F_EN        7
`define TBPWM_F_OUT       5
`define TBPWM_F_POL       4
`define TBPWM_F_ON        7
`define TBPWM_F_CKPS_HI   6
`define TBPWM_F_CKPS_LO   4
`define TBPWM_F_DLO_HI    7
`define TBPWM_F_DLO_LO    6

// reset values
`define TBPWM_RST_DUTY_UP 8'h00
`define TBPWM_RST_DUTY_LO 2'h0
`define TBPWM_RST_LIMIT   8'hff
`define TBPWM_RST_CKPS    3'h0

// timing: last sub-count step before the timer steps, and resolution floor
`define TBPWM_SUB_LAST    2'h3
`define TBPWM_RES_BASE    4'h2

`endif

// ===== rtl/tbpwm_pkg.sv
package tbpwm_pkg;

  // register port request, one cycle long
  typedef struct packed {
    logic [2:0] addr;   // register offset
    logic [7:0] wdata;  // write data
    logic       wr;     // write strobe
    logic       rd;     // read strobe
  } tbpwm_bus_s;

  // whole state of the main module
  typedef struct packed {
    logic [7:0] duty_up;  // duty bits 9..2
    logic [1:0] duty_lo;  // duty bits 1..0
    logic       en;       // module enable, drives pin direction
    logic       output_polarity_select;      // output polarity select
    logic       ton;      // period timer on
    logic [2:0] ckps;     // timer prescale select
    logic [7:0] limit;    // period limit value
    logic [7:0] tmr;      // period timer count
    logic [1:0] sub;      // low-order sub-count
    logic [9:0] duty;     // duty value in use this period
    logic       pin;      // pin level
    logic       oe;       // pin output enable
    logic [7:0] rdata;    // read data
  } tbpwm_main_s;

  // prescaler state
  typedef struct packed {
    logic [6:0] cnt;  // edges since last tick
  } tbpwm_pre_s;

endpackage : tbpwm_pkg

// ===== rtl/tbpwm_prescale.sv
`timescale 1ns/100ps
`include "tbpwm_params.svh"

// divides the system clock by 1..128 into a one-cycle tick
module tbpwm_prescale
  import tbpwm_pkg::*;
(
  input  logic       clock_i,  // system clock
  input  logic       rst_i,    // sync reset, active high
  input  logic       run_i,    // count enable (timer on, awake)
  input  logic       clr_i,    // restart division
  input  logic [2:0] ckps_i,   // prescale select
  output logic       tick_o    // one-cycle timer clock
);

  tbpwm_pre_s s;       // current state
  tbpwm_pre_s next_s;  // next state
  logic [6:0] last;    // terminal count for this ratio

  // terminal count is ratio minus one; code n gives 2**n
  always_comb begin
    last   = 7'((8'h01 << ckps_i) - 8'h01);
    // at or past the end, so a ratio cut short mid-count ticks at once
    // instead of running the counter round through all 128 steps
    tick_o = run_i && (s.cnt >= last);
    next_s = s;
    if (clr_i) begin
      next_s.cnt = 7'h00;
    end else if (run_i) begin
      // frozen while asleep so the phase survives a nap
      next_s.cnt = tick_o ? 7'h00 : 7'(s.cnt + 7'h01);
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : tbpwm_prescale

// ===== rtl/tbpwm_res.sv
`timescale 1ns/100ps
`include "tbpwm_params.svh"

// resolution in bits: floor(log2(4 * (limit + 1)))
module tbpwm_res
  import tbpwm_pkg::*;
(
  input  logic [7:0] limit_i,  // period limit value
  output logic [3:0] bits_o    // resolution in whole bits
);

  logic [8:0] steps;  // limit plus one, never zero

  // position of the top set bit, plus two for the sub-count
  always_comb begin
    steps  = 9'({1'b0, limit_i} + 9'h001);
    bits_o = `TBPWM_RES_BASE;
    for (int i = 1; i < 9; i++) begin
      if (steps[i]) begin
        bits_o = 4'(i + 2);
      end
    end
  end

endmodule : tbpwm_res

// ===== rtl/tbpwm_top.sv
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/100ps
`include "tbpwm_params.svh"

// Operation
// - count at limit clears on the tick that wraps the sub-count
// - resolution is log2 of 4*(limit+1)
// - duty above period holds pin level
// - sleep freezes timer, state and pin
// - wake resumes count where it stopped
// - reset: pin input, registers to defaults
// - upper duty register holds bits 9..2
// - lower register bits 7..6, rest zero
// - timebase comes from system clock
// - prescale codes 0..7 divide 1..128
module tbpwm_top
  import tbpwm_pkg::*;
(
  input  logic       clock_i,   // system clock, 125 MHz
  input  logic       rst_i,     // sync reset, active high
  input  tbpwm_bus_s bus_i,     // register port request
  input  logic       sleep_i,   // device asleep, level
  output logic [7:0] rdata_o,   // read data, cycle after strobe
  output logic       pwm_o,     // pwm pin level
  output logic       pwm_oe_o   // pwm pin driven when high
);

  tbpwm_main_s s;         // current state
  tbpwm_main_s next_s;    // next state
  logic        tick;      // one timer clock from the prescaler
  logic        run;       // timer may advance this cycle
  logic        wrap;      // sub-count leaves its last step
  logic        roll;      // period ends on this tick
  logic [9:0]  cnt;       // 10-bit position in the period
  logic [10:0] period;    // period length in sub-count steps
  logic        ovr;       // duty exceeds period
  logic        active;    // pulse part of the period
  logic [3:0]  res_bits;  // current resolution

  // timer clock is system clock through the prescaler
  assign run = s.ton && !sleep_i;

  tbpwm_prescale u_pre (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .run_i   (run),
    .clr_i   (!s.ton),
    .ckps_i  (s.ckps),
    .tick_o  (tick)
  );

  tbpwm_res u_res (
    .limit_i (s.limit),
    .bits_o  (res_bits)
  );

  // period decode and comparator
  always_comb begin
    wrap   = tick && (s.sub == `TBPWM_SUB_LAST);
    roll   = wrap && (s.tmr == s.limit);
    cnt    = {s.tmr, s.sub};
    period = 11'({1'b0, s.limit, 2'h0} + 11'h004);
    ovr    = ({1'b0, s.duty} > period);
    active = (cnt < s.duty);
  end

  // next state: register port, timer, duty latch, pin
  always_comb begin
    next_s       = s;
    next_s.rdata = 8'h00;

    // writes from the register port
    if (bus_i.wr) begin
      case (bus_i.addr)
        `TBPWM_A_DUTY_UP: begin
          next_s.duty_up = bus_i.wdata;
        end
        `TBPWM_A_DUTY_LO: begin
          next_s.duty_lo = bus_i.wdata[`TBPWM_F_DLO_HI:`TBPWM_F_DLO_LO];
        end
        `TBPWM_A_CTRL: begin
          next_s.en  = bus_i.wdata[`TBPWM_F_EN];
          next_s.output_polarity_select = bus_i.wdata[`TBPWM_F_POL];
        end
        `TBPWM_A_TCTRL: begin
          next_s.ton  = bus_i.wdata[`TBPWM_F_ON];
          next_s.ckps = bus_i.wdata[`TBPWM_F_CKPS_HI:`TBPWM_F_CKPS_LO];
        end
        `TBPWM_A_LIMIT: begin
          next_s.limit = bus_i.wdata;
        end
        default: begin
          // count and resolution are read only; others unmapped
        end
      endcase
    end

    // reads answer in the next cycle; unmapped offsets read zero
    if (bus_i.rd) begin
      case (bus_i.addr)
        `TBPWM_A_DUTY_UP: begin
          next_s.rdata = s.duty_up;
        end
        `TBPWM_A_DUTY_LO: begin
          next_s.rdata = {s.duty_lo, 6'h00};
        end
        `TBPWM_A_CTRL: begin
          next_s.rdata[`TBPWM_F_EN]  = s.en;
          next_s.rdata[`TBPWM_F_OUT] = s.pin;
          next_s.rdata[`TBPWM_F_POL] = s.output_polarity_select;
        end
        `TBPWM_A_TCTRL: begin
          next_s.rdata[`TBPWM_F_ON] = s.ton;
          next_s.rdata[`TBPWM_F_CKPS_HI:`TBPWM_F_CKPS_LO] = s.ckps;
        end
        `TBPWM_A_LIMIT: begin
          next_s.rdata = s.limit;
        end
        `TBPWM_A_COUNT: begin
          next_s.rdata = s.tmr;
        end
        `TBPWM_A_RES: begin
          next_s.rdata = {4'h0, res_bits};
        end
        default: begin
          next_s.rdata = 8'h00;
        end
      endcase
    end

    // timer advances only on a tick, so sleep and off both hold it
    if (tick) begin
      next_s.sub = 2'(s.sub + 2'h1);
      if (roll) begin
        next_s.tmr = 8'h00;
      end else if (wrap) begin
        next_s.tmr = 8'(s.tmr + 8'h01);
      end
    end

    // duty is double-buffered: taken only at the period boundary,
    // or freely while the timer is off, so no runt pulse appears
    if (roll || !s.ton) begin
      next_s.duty = {s.duty_up, s.duty_lo};
    end

    // pin follows the comparator unless asleep, disabled or oversize
    if (s.en && !sleep_i && !ovr) begin
      next_s.pin = active ^ s.output_polarity_select;
    end

    // direction follows enable; reset leaves the pin an input
    next_s.oe = s.en;
  end

  // state register with synchronous reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s         <= '0;
      s.duty_up <= `TBPWM_RST_DUTY_UP;
      s.duty_lo <= `TBPWM_RST_DUTY_LO;
      s.limit   <= `TBPWM_RST_LIMIT;
      s.ckps    <= `TBPWM_RST_CKPS;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign rdata_o  = s.rdata;
  assign pwm_o    = s.pin;
  assign pwm_oe_o = s.oe;

  // checks, all on the system clock
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // a nap of at least one cycle followed by waking
  sequence s_nap;
    sleep_i ##1 !sleep_i;
  endsequence

  // write to the upper duty register then read it back
  sequence s_up_wr_rd;
    (bus_i.wr && bus_i.addr == `TBPWM_A_DUTY_UP) ##1
    (bus_i.rd && bus_i.addr == `TBPWM_A_DUTY_UP);
  endsequence

  a_timer_wrap: assert property (
    roll |=> (s.tmr == 8'h00) && (s.sub == 2'h0))
    else $error("timer did not clear after reaching limit");

  a_res_full: assert property (
    (s.limit == 8'hff) |-> (res_bits == 4'ha))
    else $error("resolution not ten bits at full limit");

  a_over_hold: assert property (
    (ovr && !bus_i.wr) |=> $stable(s.pin))
    else $error("pin moved while duty exceeds period");

  a_sleep_freeze: assert property (
    sleep_i |=> $stable(s.tmr) && $stable(s.sub) && $stable(s.pin))
    else $error("state changed during sleep");

  a_wake_resume: assert property (
    s_nap |-> (s.tmr == $past(s.tmr)) && (s.sub == $past(s.sub)))
    else $error("timer reloaded on wake");

  a_up_readback: assert property (
    s_up_wr_rd |=> (rdata_o == $past(bus_i.wdata, 2)))
    else $error("upper duty read back wrong");

  a_lo_zero: assert property (
    (bus_i.rd && bus_i.addr == `TBPWM_A_DUTY_LO) |=> (rdata_o[5:0] == 6'h00))
    else $error("unimplemented duty bits not zero");

  a_pin_level: assert property (
    (s.en && !sleep_i && !ovr) |=> (pwm_o == ($past(active) ^ $past(s.output_polarity_select))))
    else $error("pin level disagrees with comparator");

  a_duty_hold: assert property (
    (s.ton && !roll) |=> $stable(s.duty))
    else $error("duty changed inside a period");

  a_fast_tick: assert property (
    (s.ton && !sleep_i && s.ckps == 3'h0) ##1 (s.ton && !sleep_i && s.ckps == 3'h0) |-> tick)
    else $error("divide by one did not tick every cycle");

  // a write to the upper duty register
  sequence s_up_wr;
    bus_i.wr && (bus_i.addr == `TBPWM_A_DUTY_UP);
  endsequence

  // a write to the lower duty register
  sequence s_lo_wr;
    bus_i.wr && (bus_i.addr == `TBPWM_A_DUTY_LO);
  endsequence

  // a write to the period limit
  sequence s_lim_wr;
    bus_i.wr && (bus_i.addr == `TBPWM_A_LIMIT);
  endsequence

  // reset checks must run while reset is high, so they drop the default
  a_reset_out: assert property (
    @(posedge clock_i) disable iff (1'b0)
    rst_i |=> (!pwm_oe_o && !pwm_o && (rdata_o == 8'h00)))
    else $error("outputs not idle after reset");

  // every register but the polarity bit back to its default, timer stopped and cleared
  a_reset_regs: assert property (
    @(posedge clock_i) disable iff (1'b0)
    rst_i |=> (s.limit == `TBPWM_RST_LIMIT) &&
              (s.duty_up == `TBPWM_RST_DUTY_UP) &&
              (s.duty_lo == `TBPWM_RST_DUTY_LO) &&
              (s.ckps == `TBPWM_RST_CKPS) &&
              !s.en && !s.ton && (s.tmr == 8'h00))
    else $error("registers not at defaults after reset");

  // pin direction trails the enable bit by one cycle
  a_oe_follow: assert property (
    1'b1 |=> (pwm_oe_o == $past(s.en)))
    else $error("pin direction does not follow enable");

  // upper duty write lands whole
  a_up_write: assert property (
    s_up_wr |=> (s.duty_up == $past(bus_i.wdata)))
    else $error("upper duty write lost");

  // only the top two bits of the lower duty write are kept
  a_lo_write: assert property (
    s_lo_wr |=> (s.duty_lo == $past(bus_i.wdata[7:6])))
    else $error("lower duty write lost");

  // limit write lands whole
  a_lim_write: assert property (
    s_lim_wr |=> (s.limit == $past(bus_i.wdata)))
    else $error("limit write lost");

  // limit moves only on its own write
  a_lim_hold: assert property (
    !(bus_i.wr && (bus_i.addr == `TBPWM_A_LIMIT)) |=> $stable(s.limit))
    else $error("limit changed without a write");

  // read data stands one cycle only, so an idle cycle reads zero
  a_rd_idle: assert property (
    !bus_i.rd |=> (rdata_o == 8'h00))
    else $error("read data left standing");

  // the unmapped offset reads zero
  a_gap_zero: assert property (
    (bus_i.rd && (bus_i.addr == 3'h7)) |=> (rdata_o == 8'h00))
    else $error("unmapped offset not zero");

  // count reads show the timer as it stood at the strobe
  a_count_read: assert property (
    (bus_i.rd && (bus_i.addr == `TBPWM_A_COUNT)) |=> (rdata_o == $past(s.tmr)))
    else $error("count read wrong");

  // resolution reads carry the computed width
  a_res_read: assert property (
    (bus_i.rd && (bus_i.addr == `TBPWM_A_RES)) |=> (rdata_o == {4'h0, $past(res_bits)}))
    else $error("resolution read wrong");

  // smallest period: four sub-count steps, two bits
  a_res_floor: assert property (
    (s.limit == 8'h00) |-> (res_bits == 4'h2))
    else $error("resolution wrong at zero limit");

  // 4 * 64 steps give eight bits
  a_res_mid: assert property (
    (s.limit == 8'h3f) |-> (res_bits == 4'h8))
    else $error("resolution wrong at middle limit");

  // the status bit shows the pin as it stood at the strobe
  a_out_read: assert property (
    (bus_i.rd && (bus_i.addr == `TBPWM_A_CTRL)) |=> (rdata_o[`TBPWM_F_OUT] == $past(s.pin)))
    else $error("pin status read wrong");

  // each tick moves the sub-count one step
  a_sub_step: assert property (
    tick |=> (s.sub == 2'($past(s.sub) + 2'h1)))
    else $error("sub-count did not step");

  // the count steps once per sub-count wrap below the limit
  a_tmr_step: assert property (
    (wrap && !roll) |=> (s.tmr == 8'($past(s.tmr) + 8'h01)))
    else $error("timer did not step on wrap");

  // no timer clock while asleep or off
  a_idle_no_tick: assert property (
    (sleep_i || !s.ton) |-> !tick)
    else $error("tick while asleep or off");

  // off holds the count, so turning on resumes from it
  a_off_hold: assert property (
    !s.ton |=> $stable(s.tmr) && $stable(s.sub))
    else $error("timer moved while off");

  // divide by two: never two ticks in a row
  a_half_tick: assert property (
    (tick && s.ckps == 3'h1) ##1 (s.ckps == 3'h1) |-> !tick)
    else $error("divide by two ticked twice in a row");

  // the working duty takes the pair at the period boundary
  a_duty_load: assert property (
    roll |=> (s.duty == $past({s.duty_up, s.duty_lo})))
    else $error("duty not loaded at period end");

  // with the timer off the working duty follows the registers
  a_off_load: assert property (
    !s.ton |=> (s.duty == $past({s.duty_up, s.duty_lo})))
    else $error("duty not loaded while off");

  // a disabled module leaves the pin level alone
  a_dis_hold: assert property (
    !s.en |=> $stable(pwm_o))
    else $error("pin moved while disabled");

endmodule : tbpwm_top

// ===== verification/tbpwm_load.sv
`timescale 1ns/100ps
// pin load: when released the wire shows the inverse of the last driven
// level, so a released pin is never mistaken for a driven one
module tbpwm_load (
  input  wire logic clock_i,  // system clock
  input  wire logic drv_i,    // level from the block
  input  wire logic oe_i,     // block drives the pin
  output logic      pin_o     // level seen on the wire
);
  logic last;  // last driven level
  // remember what the block last drove
  always_ff @(posedge clock_i) begin
    if (oe_i) last <= drv_i;
  end
  assign pin_o = oe_i ? drv_i : ~last;
endmodule : tbpwm_load

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`include "tbpwm_params.svh"
// counts every compare, reports and counts a mismatch
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import tbpwm_pkg::*;
  logic       clock_i = 0;  // system clock, 8 ns
  logic       rst_i = 1;    // sync reset
  tbpwm_bus_s bus = '0;     // register request
  logic       sleep = 0;    // device asleep
  logic [7:0] rdata;        // read data
  logic       pwm, oe, pin; // pin level, enable, wire
  logic [8:0] q[$];         // pending reads: check flag, value
  logic [8:0] e;            // oldest note
  logic       rdq = 0;      // read strobe one cycle late
  logic [7:0] got, c1, d;   // last read data, scratch
  logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h0a, 8'h00};
  logic [7:0] pv[2] = '{8'h90, 8'h80};  // control: with and without polarity
  int         n_fail = 0, checked = 0, cyc = 0, h;

  tbpwm_top u_tbpwm_top (.clock_i(clock_i), .rst_i(rst_i), .bus_i(bus), .sleep_i(sleep),
                         .rdata_o(rdata), .pwm_o(pwm), .pwm_oe_o(oe));
  tbpwm_load u_tbpwm_load (.clock_i(clock_i), .drv_i(pwm), .oe_i(oe), .pin_o(pin));

  always #4 clock_i = ~clock_i;

  // read data stands only in the cycle after the strobe, so look there;
  // the run needs about 4500 cycles, the ceiling leaves wide margin
  always @(posedge clock_i) begin
    rdq <= bus.rd;
    if (rdq) begin
      e = q.pop_front();
      got = rdata;
      if (e[8]) `CHK("rdata", e[7:0], rdata)
    end
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock_i);
    bus <= '0;
    @(posedge clock_i);
  endtask : wr

  // write then read back at once, strobes with no gap between them
  task automatic wrrd(input logic [2:0] a, input logic [7:0] v, input logic [7:0] x);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge clock_i);
    q.push_back({1'b1, x});
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_i);
    bus <= '0;
    repeat (2) @(posedge clock_i);
  endtask : wrrd

  // the extra edge lets the monitor take the data before we use it
  task automatic rd(input logic [2:0] a, input logic [7:0] v, input logic c = 1'b1);
    q.push_back({c, v});
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock_i);
    bus <= '0;
    repeat (2) @(posedge clock_i);
  endtask : rd

  // count wire-high cycles, sampled mid-cycle
  task automatic hi(input int n);
    h = 0;
    repeat (n) begin
      @(negedge clock_i);
      h += (pin === 1'b1);
    end
    @(posedge clock_i);
  endtask : hi

  function automatic logic [7:0] res(input logic [7:0] l);
    int v;
    v = 4 * (l + 1);
    res = 0;
    while (v > 1) begin
      v >>= 1;
      res++;
    end
  endfunction : res

  task automatic done(input string s);
    $display("test %s done, %0d checks, %0d bad", s, checked, n_fail);
  endtask : done

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    h = $urandom(2);
    repeat (8) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    `CHK("oe", 1'b0, oe)
    // defaults, then writes to read-only and unmapped places change nothing
    for (int k = 0; k < 2; k++) begin
      foreach (rv[a]) rd(a[2:0], rv[a]);
      for (int a = 5; a < 8; a++) wr(a[2:0], 8'($urandom));
    end
    d = 8'($urandom);
    wr(`TBPWM_A_DUTY_UP, d);
    rd(`TBPWM_A_DUTY_UP, d);
    wr(`TBPWM_A_DUTY_LO, d);
    rd(`TBPWM_A_DUTY_LO, d & 8'hc0);
    wrrd(`TBPWM_A_DUTY_UP, ~d, ~d);
    wrrd(`TBPWM_A_DUTY_LO, ~d, ~d & 8'hc0);
    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom);
      wr(`TBPWM_A_LIMIT, d);
      rd(`TBPWM_A_RES, res(d));
    end
    done("registers");
    // duty 2 of a 4-step period: half the cycles high at every prescale
    wr(`TBPWM_A_LIMIT, 8'h00);
    wr(`TBPWM_A_DUTY_UP, 8'h00);
    wr(`TBPWM_A_DUTY_LO, 8'h80);
    wr(`TBPWM_A_CTRL, 8'h80);
    for (int n = 0; n < 8; n++) begin
      wr(`TBPWM_A_TCTRL, {1'b1, n[2:0], 4'h0});
      repeat (8 << n) @(posedge clock_i);
      hi(8 << n);
      `CHK("highs", 4 << n, h)
    end
    `CHK("oe", 1'b1, oe)
    rd(`TBPWM_A_COUNT, 8'h00);
    done("prescale");
    wr(`TBPWM_A_TCTRL, 8'h80);
    wr(`TBPWM_A_DUTY_LO, 8'h00);
    foreach (pv[i]) begin
      wr(`TBPWM_A_CTRL, pv[i]);
      repeat (8) @(posedge clock_i);
      hi(16);
      `CHK("level", (pv[i][4] ? 16 : 0), h)
      rd(`TBPWM_A_CTRL, {pv[i][7:6], pv[i][4], pv[i][4:0]});
    end
    done("polarity");
    // a duty above the period must freeze a toggling pin
    wr(`TBPWM_A_DUTY_LO, 8'h80);
    repeat (8) @(posedge clock_i);
    wr(`TBPWM_A_DUTY_UP, 8'h01);
    wr(`TBPWM_A_DUTY_LO, 8'h40);
    repeat (8) @(posedge clock_i);
    hi(32);
    `CHK("held", 1'b1, (h == 0 || h == 32))
    wr(`TBPWM_A_DUTY_LO, 8'h00);
    repeat (8) @(posedge clock_i);
    hi(32);
    `CHK("full", 32, h)
    done("oversize");
    wr(`TBPWM_A_LIMIT, 8'hff);
    wr(`TBPWM_A_DUTY_UP, 8'h80);
    repeat (20) @(posedge clock_i);
    sleep <= 1;
    repeat (2) @(posedge clock_i);
    rd(`TBPWM_A_COUNT, 8'h00, 1'b0);
    c1 = got;
    hi(40);
    `CHK("frozen", 1'b1, (h == 0 || h == 40))
    rd(`TBPWM_A_COUNT, c1);
    sleep <= 0;
    repeat (8) @(posedge clock_i);
    rd(`TBPWM_A_COUNT, 8'h00, 1'b0);
    d = got - c1;
    `CHK("resume", 1'b1, (d > 0 && d < 4))
    done("sleep");
    // a second reset in mid-run must restore every default
    rst_i <= 1;
    repeat (2) @(posedge clock_i);
    rst_i <= 0;
    @(posedge clock_i);
    `CHK("oe", 1'b0, oe)
    foreach (rv[a]) rd(a[2:0], rv[a]);
    done("reset");
    final_report();
  end
endmodule : tb_top
